// *** common/msc_pkg.sv ***
// Shared constants, types and register map of the sideband control block
package msc_pkg;
    // Clock and timing
    localparam int unsigned MSC_CLK_PERIOD_NS = 40;
    localparam int unsigned MSC_RESET_PULSE_MIN_NS = 10000;
    localparam int unsigned MSC_RESET_PULSE_MIN_CYC =
        (MSC_RESET_PULSE_MIN_NS + MSC_CLK_PERIOD_NS - 1) / MSC_CLK_PERIOD_NS;
    localparam int unsigned MSC_RESET_SETTLE_NS = 2000000;
    localparam int unsigned MSC_RESET_SETTLE_CYC = MSC_RESET_SETTLE_NS / MSC_CLK_PERIOD_NS;
    localparam int unsigned MSC_CNT_W = 24;

    // Register byte offsets
    localparam logic [11:0] MSC_ADDR_STATUS = 12'h000;
    localparam logic [11:0] MSC_ADDR_CLEAR = 12'h004;
    localparam logic [11:0] MSC_ADDR_ENABLE = 12'h008;
    localparam logic [11:0] MSC_ADDR_CONTROL = 12'h00C;
    localparam logic [11:0] MSC_ADDR_STATE = 12'h010;

    // Event bits of status, clear and enable
    localparam int unsigned MSC_EV_W = 3;
    localparam int unsigned MSC_EV_DONE = 0;
    localparam int unsigned MSC_EV_FAULT = 1;
    localparam int unsigned MSC_EV_LP = 2;
    localparam logic [MSC_EV_W-1:0] MSC_EV_RST = 3'h0;

    // Control bits (user settings)
    localparam int unsigned MSC_CTRL_W = 2;
    localparam int unsigned MSC_CTRL_FAULT = 0;
    localparam int unsigned MSC_CTRL_LP = 1;
    localparam logic [MSC_CTRL_W-1:0] MSC_CTRL_RST = 2'h0;

    // State register bits
    localparam int unsigned MSC_ST_W = 5;
    localparam int unsigned MSC_ST_PENDING = 0;
    localparam int unsigned MSC_ST_LOWPWR = 1;
    localparam int unsigned MSC_ST_SELECTED = 2;
    localparam int unsigned MSC_ST_INT_PIN = 3;
    localparam int unsigned MSC_ST_RST_PIN = 4;

    // Sampled sideband pins
    typedef struct packed {
        logic select_n;
        logic reset_n;
        logic low_power;
        logic scl;
        logic sda;
        logic int_n;
    } msc_pins_s;
    localparam msc_pins_s MSC_PINS_RST = 6'h37;

    typedef enum logic [1:0] {
        MSC_SEQ_SETTLE,
        MSC_SEQ_RUN,
        MSC_SEQ_LOW
    } msc_seq_e;
endpackage : msc_pkg

// *** rtl/msc_pin_sync.sv ***
// Three-stage pin synchroniser, output follows once stages two and three agree
`timescale 1ns/1ps
module msc_pin_sync
    import msc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire msc_pins_s d_i,
    output msc_pins_s q_o
);
    genvar g;
    for (g = 0; g < $bits(msc_pins_s); g++)
    begin : g_bit
        logic s1;
        logic s2;
        logic s3;
        logic q;
        logic next_q;
        always_comb
        begin
            next_q = (s2 == s3) ? s3 : q;
        end
        always_ff @(posedge clk_i)
        begin
            if (!rst_n_i)
            begin
                s1 <= MSC_PINS_RST[g];
                s2 <= MSC_PINS_RST[g];
                s3 <= MSC_PINS_RST[g];
                q <= MSC_PINS_RST[g]; // Select idles deselected
            end
            else
            begin
                s1 <= d_i[g];
                s2 <= s1;
                s3 <= s2;
                q <= next_q;
            end
        end
        assign q_o[g] = q;
    end
endmodule : msc_pin_sync

// *** rtl/msc_reset_seq.sv ***
// Module reset sequencer: pulse qualification, settle timing, completion
`timescale 1ns/1ps
module msc_reset_seq
    import msc_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = MSC_RESET_SETTLE_CYC
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic reset_pin_n_i,
    output logic pending_o,
    output logic defaults_o,
    output logic done_o
);
    localparam logic [MSC_CNT_W-1:0] PULSE = MSC_CNT_W'(MSC_RESET_PULSE_MIN_CYC);
    localparam logic [MSC_CNT_W-1:0] SETTLE_LAST = MSC_CNT_W'(SETTLE_CYCLES - 1);

    msc_seq_e state;
    msc_seq_e next_state;
    logic [MSC_CNT_W-1:0] cnt;
    logic [MSC_CNT_W-1:0] next_cnt;
    logic next_pending;
    logic next_defaults;
    logic next_done;

    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_pending = pending_o;
        next_defaults = 1'b0;
        next_done = 1'b0;
        // Pending drops in the update that posts completion
        if (done_o)
        begin
            next_pending = 1'b0;
        end
        case (state)
            MSC_SEQ_SETTLE:
            begin
                if (!reset_pin_n_i)
                begin
                    next_state = MSC_SEQ_LOW;
                    next_cnt = '0;
                end
                else if (cnt == SETTLE_LAST)
                begin
                    // Completion pulse, posted on the interrupt pin next
                    next_state = MSC_SEQ_RUN;
                    next_done = 1'b1;
                    next_cnt = '0;
                end
                else
                begin
                    next_cnt = cnt + 1'b1;
                end
            end
            MSC_SEQ_RUN:
            begin
                if (!reset_pin_n_i)
                begin
                    next_state = MSC_SEQ_LOW;
                    next_cnt = '0;
                end
            end
            MSC_SEQ_LOW:
            begin
                if (reset_pin_n_i)
                begin
                    // Settle time counts from the releasing edge
                    next_state = pending_o ? MSC_SEQ_SETTLE : MSC_SEQ_RUN;
                    next_cnt = '0;
                end
                else if (cnt != PULSE)
                begin
                    next_cnt = cnt + 1'b1;
                end
                else if (!pending_o)
                begin
                    // Long enough low: full reset, defaults restored
                    next_pending = 1'b1;
                    next_defaults = 1'b1;
                end
            end
            default:
            begin
                next_state = MSC_SEQ_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            // Power-up starts a settle by itself
            state <= MSC_SEQ_SETTLE;
            cnt <= '0;
            pending_o <= 1'b1;
            defaults_o <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            pending_o <= next_pending;
            defaults_o <= next_defaults;
            done_o <= next_done;
        end
    end
endmodule : msc_reset_seq

// *** rtl/msc_sideband_ctrl.sv ***
// Sideband pin control of a pluggable module with an APB register slave
// Operation
// - With the select pin low, 2-wire traffic passes to the management slave.
// - With the select pin high, 2-wire traffic is ignored and no reply is driven.
// - The select pin reads as high out of reset, so the module starts deselected.
// - A reset pin low longer than the minimum pulse, with init not pending, restores the control settings.
// - The settle interval starts at the rising edge that ends the reset pulse.
// - Completion is signalled by pulling the interrupt pin with init pending clear.
// - After power-up the completion interrupt is posted without a reset pulse.
// - The low-power request pin puts the module into its reduced-power state.
// - The interrupt pin is pulled low while a completion or a fault is posted.
// - The interrupt pin is only pulled low or released, never driven high.
`timescale 1ns/1ps
module msc_sideband_ctrl
    import msc_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = MSC_RESET_SETTLE_CYC
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic module_select_n_i,
    input wire logic module_reset_n_i,
    input wire logic low_power_request_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic interrupt_out_n_i,
    output logic interrupt_out_n_o,
    output logic interrupt_out_oe_o,
    input wire logic twi_sda_pull_i,
    output logic twi_scl_o,
    output logic twi_sda_o,
    input wire logic fault_event_i,
    output logic settings_default_o,
    output logic init_pending_o,
    output logic low_power_mode_o,
    output logic irq_o
);
    msc_pins_s pins_raw;
    msc_pins_s pins;
    logic seq_pending;
    logic seq_defaults;
    logic seq_done;

    logic [MSC_EV_W-1:0] status;
    logic [MSC_EV_W-1:0] next_status;
    logic [MSC_EV_W-1:0] enable;
    logic [MSC_EV_W-1:0] next_enable;
    logic [MSC_CTRL_W-1:0] control;
    logic [MSC_CTRL_W-1:0] next_control;
    logic [MSC_EV_W-1:0] events;
    logic [MSC_EV_W-1:0] clear_mask;
    logic next_lp;
    logic next_int_oe;
    logic next_irq;
    logic next_sda_oe;
    logic next_twi_scl;
    logic next_twi_sda;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_slverr;
    logic access;
    logic wr;
    logic [MSC_ST_W-1:0] state_word;

    always_comb
    begin
        pins_raw = '{select_n: module_select_n_i, reset_n: module_reset_n_i,
                     low_power: low_power_request_i, scl: scl_i, sda: sda_i,
                     int_n: interrupt_out_n_i};
    end

    // Pin sampling fast enough for a 400 kHz 2-wire clock
    msc_pin_sync u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i(pins_raw),
        .q_o(pins)
    );

    msc_reset_seq #(
        .SETTLE_CYCLES(SETTLE_CYCLES)
    ) u_seq (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .reset_pin_n_i(pins.reset_n),
        .pending_o(seq_pending),
        .defaults_o(seq_defaults),
        .done_o(seq_done)
    );

    assign settings_default_o = seq_defaults;
    assign init_pending_o = seq_pending;

    // APB handshake, one wait state per access
    assign access = psel_i && penable_i && pready_o;
    assign wr = access && pwrite_i;

    always_comb
    begin
        state_word = '0;
        state_word[MSC_ST_PENDING] = seq_pending;
        state_word[MSC_ST_LOWPWR] = low_power_mode_o;
        state_word[MSC_ST_SELECTED] = !pins.select_n;
        state_word[MSC_ST_INT_PIN] = pins.int_n;
        state_word[MSC_ST_RST_PIN] = pins.reset_n;
        next_pready = psel_i && penable_i && !pready_o;
        next_prdata = 32'h0000_0000;
        next_slverr = 1'b0;
        if (next_pready)
        begin
            case (paddr_i)
                MSC_ADDR_STATUS: next_prdata = 32'(status);
                MSC_ADDR_CLEAR: next_prdata = 32'h0000_0000;
                MSC_ADDR_ENABLE: next_prdata = 32'(enable);
                MSC_ADDR_CONTROL: next_prdata = 32'(control);
                MSC_ADDR_STATE: next_prdata = 32'(state_word);
                default: next_slverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            pready_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end
        else
        begin
            pready_o <= next_pready;
            prdata_o <= next_prdata;
            pslverr_o <= next_slverr;
        end
    end

    // Settings, events, interrupt and pin drive
    always_comb
    begin
        next_control = control;
        if (wr && paddr_i == MSC_ADDR_CONTROL)
        begin
            next_control = pwdata_i[MSC_CTRL_W-1:0];
        end
        if (seq_defaults)
        begin
            next_control = MSC_CTRL_RST;
        end
        next_enable = enable;
        if (wr && paddr_i == MSC_ADDR_ENABLE)
        begin
            next_enable = pwdata_i[MSC_EV_W-1:0];
        end
        clear_mask = '0;
        if (wr && paddr_i == MSC_ADDR_CLEAR)
        begin
            clear_mask = pwdata_i[MSC_EV_W-1:0];
        end
        // Low-power request or software force
        next_lp = pins.low_power || next_control[MSC_CTRL_LP];
        events = '0;
        events[MSC_EV_DONE] = seq_done;
        events[MSC_EV_FAULT] = fault_event_i ||
            (next_control[MSC_CTRL_FAULT] && !control[MSC_CTRL_FAULT]);
        events[MSC_EV_LP] = next_lp != low_power_mode_o;
        // Set wins over a clear in the same cycle
        next_status = (status & ~clear_mask) | events;
        next_irq = |(next_status & next_enable);
        // Pin pulled while completion or fault is posted
        next_int_oe = next_status[MSC_EV_DONE] || next_status[MSC_EV_FAULT];
        // Deselected: bus idles high toward the slave, no reply driven
        next_twi_scl = pins.select_n ? 1'b1 : pins.scl;
        next_twi_sda = pins.select_n ? 1'b1 : pins.sda;
        next_sda_oe = !pins.select_n && twi_sda_pull_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            control <= MSC_CTRL_RST;
            enable <= MSC_EV_RST;
            status <= MSC_EV_RST;
            low_power_mode_o <= 1'b0;
            irq_o <= 1'b0;
            interrupt_out_oe_o <= 1'b0;
            interrupt_out_n_o <= 1'b0;
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            twi_scl_o <= 1'b1;
            twi_sda_o <= 1'b1;
        end
        else
        begin
            control <= next_control;
            enable <= next_enable;
            status <= next_status;
            low_power_mode_o <= next_lp;
            irq_o <= next_irq;
            interrupt_out_oe_o <= next_int_oe;
            interrupt_out_n_o <= 1'b0; // Open drain, never driven high
            sda_o <= 1'b0;
            sda_oe_o <= next_sda_oe;
            twi_scl_o <= next_twi_scl;
            twi_sda_o <= next_twi_sda;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_done;
        seq_done;
    endsequence
    sequence s_posted;
        interrupt_out_oe_o && !init_pending_o;
    endsequence

    a_selected_pass: assert property (
        !pins.select_n |=> twi_scl_o == $past(pins.scl) && twi_sda_o == $past(pins.sda))
        else $error("selected module does not pass 2-wire traffic");
    a_deselect_quiet: assert property (
        pins.select_n |=> twi_scl_o && twi_sda_o && !sda_oe_o)
        else $error("deselected module reacts to 2-wire traffic");
    a_select_pullup: assert property (@(posedge clk_i) disable iff (1'b0)
        !rst_n_i |=> pins.select_n)
        else $error("select not deselected after reset");
    a_defaults_restored: assert property (
        seq_defaults |=> control == MSC_CTRL_RST && init_pending_o)
        else $error("settings not restored by module reset");
    a_settle_from_rise: assert property (
        $rose(pins.reset_n) && init_pending_o |=> !seq_done [*2])
        else $error("completion before settle interval");
    a_done_posts_int: assert property (
        s_done |=> s_posted)
        else $error("completion not posted on interrupt pin");
    a_powerup_pending: assert property (@(posedge clk_i) disable iff (1'b0)
        !rst_n_i |=> init_pending_o && !interrupt_out_oe_o)
        else $error("power-up does not start pending settle");
    a_lowpower_follow: assert property (
        pins.low_power |=> low_power_mode_o)
        else $error("low-power request not honoured");
    a_fault_pulls_int: assert property (
        fault_event_i |=> interrupt_out_oe_o && status[MSC_EV_FAULT])
        else $error("fault does not pull interrupt pin");
    a_int_open_drain: assert property (
        interrupt_out_n_o == 1'b0)
        else $error("interrupt pin driven high");
    a_pending_clear_done: assert property (
        $fell(init_pending_o) |-> status[MSC_EV_DONE] && interrupt_out_oe_o)
        else $error("init pending cleared without completion");
endmodule : msc_sideband_ctrl

// *** verification/msc_host_model.sv ***
// Host board model: pull-ups and a paced 2-wire clock source
`timescale 1ns/1ps
module msc_host_model
    import msc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic sda_bit_i,
    input wire logic sda_oe_i,
    input wire logic sda_lvl_i,
    input wire logic int_oe_i,
    input wire logic int_lvl_i,
    output logic scl_o,
    output logic sda_o,
    output logic int_n_o
);
    logic [4:0] half;
    logic [4:0] next_half;
    logic next_scl;

    // Clock stands high outside frames; 32-cycle halves stay under the limit
    always_comb
    begin
        next_half = half + 5'h01;
        next_scl = scl_o;
        if (!run_i)
        begin
            next_half = 5'h00;
            next_scl = 1'b1;
        end
        else if (half == 5'h1F)
        begin
            next_scl = !scl_o;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            half <= 5'h00;
            scl_o <= 1'b1;
        end
        else
        begin
            half <= next_half;
            scl_o <= next_scl;
        end
    end

    // Open-drain wires with board pull-ups
    assign sda_o = sda_bit_i & !(sda_oe_i & !sda_lvl_i);
    assign int_n_o = !(int_oe_i & !int_lvl_i);
endmodule : msc_host_model

// *** verification/tb_top.sv ***
// Self-checking bench of the sideband control block
`timescale 1ns/1ps
module tb_top
    import msc_pkg::*;
;
    localparam int unsigned SETTLE = 20;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    logic sel_n, rst_pin_n, lp_req, run, sda_bit, sda_pull, fault;
    logic scl_w, sda_w, int_w, sda_o, sda_oe, int_o, int_oe;
    logic twi_scl, twi_sda, dflt, pend, lp_mode, irq;
    logic [31:0] seed = 32'h00005C69;
    int err_total = 0;
    int n_checks = 0;
    int n_dflt = 0;
    int unsigned n;

    always #20 clk_i = !clk_i;
    always @(posedge clk_i)
        if (dflt === 1'b1)
            n_dflt++;

    msc_sideband_ctrl #(.SETTLE_CYCLES(SETTLE)) msc_sideband_ctrl_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .module_select_n_i(sel_n),
        .module_reset_n_i(rst_pin_n), .low_power_request_i(lp_req), .scl_i(scl_w),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .interrupt_out_n_i(int_w),
        .interrupt_out_n_o(int_o), .interrupt_out_oe_o(int_oe),
        .twi_sda_pull_i(sda_pull), .twi_scl_o(twi_scl), .twi_sda_o(twi_sda),
        .fault_event_i(fault), .settings_default_o(dflt), .init_pending_o(pend),
        .low_power_mode_o(lp_mode), .irq_o(irq));

    msc_host_model msc_host_model_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(run), .sda_bit_i(sda_bit),
        .sda_oe_i(sda_oe), .sda_lvl_i(sda_o), .int_oe_i(int_oe), .int_lvl_i(int_o),
        .scl_o(scl_w), .sda_o(sda_w), .int_n_o(int_w));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    function automatic logic exp_irq(input logic [2:0] st, input logic [2:0] en);
        return |(st & en);
    endfunction : exp_irq

    task automatic finish_test();
        $display("Checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic chkb(input string nm, input logic s, input logic e);
        chk(nm, {31'h0, s}, {31'h0, e});
    endtask : chkb

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
    endtask : cyc

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1)
            @(posedge clk_i);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_done();
        n = 0;
        while (pend !== 1'b0 && n < 2000)
        begin
            @(posedge clk_i);
            n++;
        end
    endtask : wait_done

    task automatic pulse(input int k);
        @(posedge clk_i);
        rst_pin_n <= 1'b0;
        cyc(k);
        rst_pin_n <= 1'b1;
    endtask : pulse

    initial
    begin
        repeat (6000) @(posedge clk_i);
        err_total++;
        finish_test();
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {sel_n, lp_req, run, fault} = 4'h0;
        {rst_pin_n, sda_bit, sda_pull} = 3'h7;
        cyc(4);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        chkb("twi_scl", twi_scl, 1'b1);
        chkb("sda_oe", sda_oe, 1'b0);
        chkb("pending", pend, 1'b1);
        wait_done();
        chkb("powerup", n >= SETTLE - 2 && n <= SETTLE + 2, 1'b1);
        chkb("int_oe", int_oe, 1'b1);
        chkb("int_lvl", int_o, 1'b0);
        apb(1'b0, MSC_ADDR_STATUS, 32'h0);
        chk("status", rd, 32'h1);
        apb(1'b0, MSC_ADDR_STATE, 32'h0);
        chk("state", rd, 32'h14);
        apb(1'b1, MSC_ADDR_ENABLE, 32'h1);
        cyc(2);
        chkb("irq", irq, exp_irq(3'h1, 3'h1));
        apb(1'b1, MSC_ADDR_CLEAR, 32'h1);
        cyc(2);
        chkb("irq", irq, exp_irq(3'h0, 3'h1));
        chkb("int_pin", int_w, 1'b1);
        apb(1'b1, MSC_ADDR_ENABLE, 32'h0);
        @(posedge clk_i);
        fault <= 1'b1;
        @(posedge clk_i);
        fault <= 1'b0;
        cyc(2);
        chkb("irq", irq, exp_irq(3'h2, 3'h0));
        chkb("int_oe", int_oe, 1'b1);
        apb(1'b1, MSC_ADDR_CLEAR, 32'h2);
        apb(1'b1, MSC_ADDR_CONTROL, 32'h1);
        cyc(2);
        chkb("int_oe", int_oe, 1'b1);
        apb(1'b0, MSC_ADDR_STATUS, 32'h0);
        chk("status", rd, 32'h2);
        apb(1'b1, MSC_ADDR_CLEAR, 32'h2);
        cyc(2);
        chkb("int_oe", int_oe, 1'b0);
        repeat (8)
        begin
            v = xs();
            apb(1'b1, MSC_ADDR_ENABLE, v);
            apb(1'b0, MSC_ADDR_ENABLE, 32'h0);
            chk("enable", rd, v & 32'h7);
        end
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped", {err, rd[30:0]}, 32'h80000000);
        apb(1'b0, 12'h002, 32'h0);
        chkb("unaligned", err, 1'b1);
        apb(1'b0, MSC_ADDR_CLEAR, 32'h0);
        chk("clear_rd", rd, 32'h0);
        sda_bit <= 1'b0;
        run <= 1'b1;
        while (scl_w !== 1'b0)
            @(posedge clk_i);
        cyc(8);
        chkb("twi_scl", twi_scl, 1'b0);
        chkb("twi_sda", twi_sda, 1'b0);
        chkb("sda_oe", sda_oe, 1'b1);
        chkb("sda_lvl", sda_o, 1'b0);
        sda_pull <= 1'b0;
        cyc(2);
        chkb("sda_oe", sda_oe, 1'b0);
        sda_pull <= 1'b1;
        sel_n <= 1'b1;
        cyc(8);
        chkb("twi_scl", twi_scl, 1'b1);
        chkb("twi_sda", twi_sda, 1'b1);
        chkb("sda_oe", sda_oe, 1'b0);
        {sel_n, run, sda_bit, lp_req} <= 4'h3;
        cyc(8);
        chkb("lp_mode", lp_mode, 1'b1);
        apb(1'b0, MSC_ADDR_STATE, 32'h0);
        chkb("state_lp", rd[MSC_ST_LOWPWR], 1'b1);
        lp_req <= 1'b0;
        cyc(8);
        chkb("lp_mode", lp_mode, 1'b0);
        apb(1'b1, MSC_ADDR_CONTROL, 32'h2);
        cyc(2);
        chkb("lp_mode", lp_mode, 1'b1);
        apb(1'b1, MSC_ADDR_CLEAR, 32'h7);
        pulse(100);
        cyc(20);
        chk("short_dflt", n_dflt, 32'h0);
        chkb("pending", pend, 1'b0);
        apb(1'b0, MSC_ADDR_CONTROL, 32'h0);
        chk("control", rd, 32'h2);
        pulse(300);
        chk("long_dflt", n_dflt, 32'h1);
        chkb("pending", pend, 1'b1);
        wait_done();
        chkb("settle", n >= SETTLE + 1 && n <= SETTLE + 8, 1'b1);
        chkb("int_oe", int_oe, 1'b1);
        apb(1'b0, MSC_ADDR_CONTROL, 32'h0);
        chk("control", rd, 32'h0);
        chkb("lp_mode", lp_mode, 1'b0);
        finish_test();
    end
endmodule : tb_top
